// [wake_cfg.svh]
// constants for the reset, wake-up and strap control block
// assumes a single 50 MHz system clock; included by bare name
`ifndef WAKE_CFG_SVH
`define WAKE_CFG_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   20
`define POR_TIME_NS     10000
// least time: round up to whole cycles
`define POR_CYCLES_DFLT ((`POR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_PM_CTRL     8'h00
`define OFS_PM_STAT     8'h04
`define OFS_IRQ_STAT    8'h08
`define OFS_IRQ_MASK    8'h0C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PMC_EN_BIT      0
`define PMC_POL_BIT     1
`define PMC_PP_BIT      2
`define PMC_SLEEP_BIT   3
`define PMS_PEND_BIT    0
`define PMS_WREN_BIT    1
`define PMS_ASLEEP_BIT  2
`define PMS_STRAP_BIT   3
`define IRQ_WAKEEV_BIT  0
`define IRQ_WOKE_BIT    1
`define IRQ_REFUSE_BIT  2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PMC_RESET       4'h0
`define IRQ_RESET       3'h0

`endif

// [wake_pkg.sv]
// types shared by the reset, wake-up and strap control block
// assumes wake_cfg.svh holds the numeric constants
package wake_pkg;

  typedef logic [7:0]  reg_addr_t;
  typedef logic [31:0] reg_data_t;

  typedef enum logic [0:0] {
    PS_ACTIVE = 1'b0,
    PS_SLEEP  = 1'b1
  } power_state_t;

endpackage : wake_pkg

// [host_evt_if.sv]
// events decoded from the host bus strobes
// assumes one clock; producer is host_cycle_watch, consumer the top
`timescale 1ns/1ps
interface host_evt_if;
  logic write_start;
  logic read_done;
  logic write_cycle;

  modport watch (output write_start, output read_done, output write_cycle);
  modport core  (input  write_start, input  read_done, input  write_cycle);
endinterface : host_evt_if

// [host_cycle_watch.sv]
// edge detection on the host select and strobe pins
// assumes the pins are already synchronous to sys_clk_i
`timescale 1ns/1ps
module host_cycle_watch (
  input  wire logic   sys_clk_i,
  input  wire logic   rst_i,
  input  wire logic   host_select_n_i,
  input  wire logic   host_write_strobe_n_i,
  input  wire logic   host_read_strobe_n_i,
  host_evt_if.watch   ev
);
  logic wr_cyc;
  logic rd_cyc;
  logic wr_cyc_q;
  logic rd_cyc_q;

  // a write cycle needs select and write strobe low together
  assign wr_cyc = !host_select_n_i && !host_write_strobe_n_i;
  assign rd_cyc = !host_select_n_i && !host_read_strobe_n_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_cyc_q <= 1'b0;
      rd_cyc_q <= 1'b0;
    end else begin
      wr_cyc_q <= wr_cyc;
      rd_cyc_q <= rd_cyc;
    end
  end

  assign ev.write_start = wr_cyc && !wr_cyc_q;
  // a read counts once it has ended
  assign ev.read_done   = rd_cyc_q && !rd_cyc;
  assign ev.write_cycle = wr_cyc;

endmodule : host_cycle_watch

// [reset_wake_strap_control.sv]
// reset, wake-up and speed strap control of the ethernet controller
// assumes synchronous host pins, a 50 MHz clock, a power-good level
// from the supply monitor and a plain register port from the CSR side
//
// Summary of operation
// - while the hard reset is active every flip-flop returns to its reset value; the power-on counter is cleared only by power_good_i low.
// - with the hard reset pin left high the internal power-on reset initialises the block.
// - when enabled, a detected wake event asserts the wake-event output.
// - software selects the wake-event output polarity and push-pull or open-drain drive.
// - a wake event and its output never bring the block out of sleep.
// - sleep ends only on a host write cycle, select and write strobe low together.
// - any host write wakes the block, whatever the data and the target.
// - the speed strap is sampled as reset ends and held to choose the defaults.
// - strap 0 gives 10 Mb/s half duplex without auto-negotiation, 1 gives 100 Mb/s with it.
//
// Our own choices: the address-and-strobe port and the register offsets.
`include "wake_cfg.svh"
`timescale 1ns/1ps
module reset_wake_strap_control #(
  parameter int POR_CYCLES = `POR_CYCLES_DFLT
) (
  input  wire logic               sys_clk_i,
  input  wire logic               nrst_i,
  input  wire logic               power_good_i,
  input  wire logic               host_select_n_i,
  input  wire logic               host_write_strobe_n_i,
  input  wire logic               host_read_strobe_n_i,
  input  wire logic               wake_event_i,
  input  wire logic               speed_sel_i,
  input  wire wake_pkg::reg_addr_t reg_addr_i,
  input  wire wake_pkg::reg_data_t reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output      wake_pkg::reg_data_t reg_rdata_o,
  output      logic               irq_o,
  output      logic               wake_event_out_o,
  output      logic               wake_event_out_oe_n_o,
  output      logic               host_write_accept_o,
  output      logic               power_save_o,
  output      logic               write_enabled_o,
  output      logic               default_speed_100_o,
  output      logic               default_full_duplex_o,
  output      logic               default_autoneg_o
);
  import wake_pkg::*;

  localparam int POR_W = $clog2(POR_CYCLES + 1);

  generate
    if (POR_CYCLES < 2) begin : g_bad_por
      $error("POR_CYCLES must be at least two");
    end
  endgenerate

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  logic [POR_W-1:0] por_cnt;
  logic             por_busy;
  logic             sys_rst;

  // the power-on counter restarts whenever the supply is not good, so an
  // undriven hard reset pin still gives a full reset at power-up
  always_ff @(posedge sys_clk_i) begin
    if (!power_good_i) begin
      por_cnt <= '0;
    end else if (por_cnt != POR_W'(POR_CYCLES)) begin
      por_cnt <= por_cnt + POR_W'(1);
    end
  end

  assign por_busy = (por_cnt != POR_W'(POR_CYCLES));
  assign sys_rst  = !nrst_i || por_busy;

  // ----------------------------------------------------------------
  // host bus events
  // ----------------------------------------------------------------
  host_evt_if hev ();

  host_cycle_watch u_watch (
    .sys_clk_i             (sys_clk_i),
    .rst_i                 (sys_rst),
    .host_select_n_i       (host_select_n_i),
    .host_write_strobe_n_i (host_write_strobe_n_i),
    .host_read_strobe_n_i  (host_read_strobe_n_i),
    .ev                    (hev.watch)
  );

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  function automatic logic hit(input reg_addr_t a, input reg_addr_t ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic rd_irq;

  assign wr_ctrl = reg_wr_i && hit(reg_addr_i, `OFS_PM_CTRL);
  assign wr_stat = reg_wr_i && hit(reg_addr_i, `OFS_PM_STAT);
  assign wr_mask = reg_wr_i && hit(reg_addr_i, `OFS_IRQ_MASK);
  assign rd_irq  = reg_rd_i && hit(reg_addr_i, `OFS_IRQ_STAT);

  // ----------------------------------------------------------------
  // wake-event configuration
  // ----------------------------------------------------------------
  logic pme_en;
  logic pme_pol;
  logic pme_pp;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst) begin
      pme_en  <= 1'(`PMC_RESET >> `PMC_EN_BIT);
      pme_pol <= 1'(`PMC_RESET >> `PMC_POL_BIT);
      pme_pp  <= 1'(`PMC_RESET >> `PMC_PP_BIT);
    end else if (wr_ctrl) begin
      pme_en  <= reg_wdata_i[`PMC_EN_BIT];
      pme_pol <= reg_wdata_i[`PMC_POL_BIT];
      pme_pp  <= reg_wdata_i[`PMC_PP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  power_state_t pstate;
  power_state_t next_pstate;
  logic         sleeping;
  logic         wake_now;

  assign sleeping = (pstate == PS_SLEEP);
  // any host write cycle wakes, data and address are never looked at
  assign wake_now = sleeping && hev.write_start;

  always_comb begin
    next_pstate = pstate;
    case (pstate)
      PS_ACTIVE: begin
        if (wr_ctrl && reg_wdata_i[`PMC_SLEEP_BIT]) begin
          next_pstate = PS_SLEEP;
        end
      end
      PS_SLEEP: begin
        // the wake-event output is deliberately not a wake source
        if (hev.write_start) begin
          next_pstate = PS_ACTIVE;
        end
      end
      default: begin
        next_pstate = PS_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst) begin
      pstate <= PS_ACTIVE;
    end else begin
      pstate <= next_pstate;
    end
  end

  // ----------------------------------------------------------------
  // write gate
  // ----------------------------------------------------------------
  logic wr_en;
  logic accept;
  logic refuse;

  // the wake write itself is never taken, the host must read first
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst) begin
      wr_en <= 1'b0;
    end else if (wake_now) begin
      wr_en <= 1'b0;
    end else if (hev.read_done && !sleeping) begin
      wr_en <= 1'b1;
    end
  end

  assign accept = hev.write_start && !sleeping && wr_en;
  assign refuse = hev.write_start && !sleeping && !wr_en;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst) begin
      host_write_accept_o <= 1'b0;
    end else begin
      host_write_accept_o <= accept;
    end
  end

  // ----------------------------------------------------------------
  // wake-event indicator
  // ----------------------------------------------------------------
  logic pme_pend;
  logic pme_level;

  // set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst) begin
      pme_pend <= 1'b0;
    end else if (wake_event_i && pme_en) begin
      pme_pend <= 1'b1;
    end else if (wr_stat && reg_wdata_i[`PMS_PEND_BIT]) begin
      pme_pend <= 1'b0;
    end
  end

  assign pme_level = pme_pol ? pme_pend : !pme_pend;

  // open-drain only pulls low and floats for a high level
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst) begin
      wake_event_out_o      <= 1'b0;
      wake_event_out_oe_n_o <= 1'b1;
    end else if (pme_pp) begin
      wake_event_out_o      <= pme_level;
      wake_event_out_oe_n_o <= 1'b0;
    end else begin
      wake_event_out_o      <= 1'b0;
      wake_event_out_oe_n_o <= pme_level;
    end
  end

  // ----------------------------------------------------------------
  // speed strap
  // ----------------------------------------------------------------
  logic strap;
  logic strap_taken;

  // caught in the first clocked cycle after reset ends, then frozen
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst) begin
      strap       <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap       <= speed_sel_i;
      strap_taken <= 1'b1;
    end
  end

  assign default_speed_100_o   = strap;
  assign default_autoneg_o     = strap;
  assign default_full_duplex_o = 1'b0;

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] irq_evt;

  assign irq_evt[`IRQ_WAKEEV_BIT] = wake_event_i && pme_en;
  assign irq_evt[`IRQ_WOKE_BIT]   = wake_now;
  assign irq_evt[`IRQ_REFUSE_BIT] = refuse;

  // a read clears, but an event in that very cycle survives it
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst) begin
      irq_stat <= `IRQ_RESET;
    end else begin
      irq_stat <= (rd_irq ? `IRQ_RESET : irq_stat) | irq_evt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst) begin
      irq_mask <= `IRQ_RESET;
    end else if (wr_mask) begin
      irq_mask <= reg_wdata_i[2:0];
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // read data and status outputs
  // ----------------------------------------------------------------
  reg_data_t next_rdata;

  always_comb begin
    next_rdata = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `OFS_PM_CTRL: begin
          next_rdata[`PMC_EN_BIT]    = pme_en;
          next_rdata[`PMC_POL_BIT]   = pme_pol;
          next_rdata[`PMC_PP_BIT]    = pme_pp;
          next_rdata[`PMC_SLEEP_BIT] = sleeping;
        end
        `OFS_PM_STAT: begin
          next_rdata[`PMS_PEND_BIT]   = pme_pend;
          next_rdata[`PMS_WREN_BIT]   = wr_en;
          next_rdata[`PMS_ASLEEP_BIT] = sleeping;
          next_rdata[`PMS_STRAP_BIT]  = strap;
        end
        `OFS_IRQ_STAT: begin
          next_rdata[2:0] = irq_stat;
        end
        `OFS_IRQ_MASK: begin
          next_rdata[2:0] = irq_mask;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // data stands for exactly one cycle after the read strobe
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  assign power_save_o    = sleeping;
  assign write_enabled_o = wr_en;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_clears: assert property (
    @(posedge sys_clk_i) $past(sys_rst) |-> !power_save_o && !write_enabled_o
      && !host_write_accept_o && !irq_o && wake_event_out_oe_n_o)
    else $error("state not cleared by reset");

  a_por_fallback: assert property (
    @(posedge sys_clk_i) !power_good_i |=> sys_rst [*2])
    else $error("power-on reset did not hold the block");

  a_pme_event: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst)
    (wake_event_i && pme_en && !wr_ctrl) ##1 (pme_pp && !wr_ctrl)
      |=> !wake_event_out_oe_n_o && (wake_event_out_o == pme_pol))
    else $error("wake-event output not asserted after an event");

  a_pme_drive: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst)
    !pme_pp && $past(!pme_pp) && !$past(wr_ctrl) |-> !wake_event_out_o
      && (wake_event_out_oe_n_o == $past(pme_level)))
    else $error("open-drain drive wrong");

  a_sleep_kept: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst)
    sleeping && !hev.write_start |=> sleeping)
    else $error("left sleep without a host write");

  a_wake_write: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst)
    sleeping && !host_select_n_i && !host_write_strobe_n_i
      && !$past(!host_select_n_i && !host_write_strobe_n_i)
      |=> !power_save_o && !write_enabled_o)
    else $error("host write did not wake the block");

  a_wake_no_take: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst)
    wake_now |=> !host_write_accept_o ##1 !host_write_accept_o)
    else $error("wake write was taken as a register write");

  a_strap_held: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst)
    $past(strap_taken) |-> $stable(default_speed_100_o))
    else $error("strap value changed after sampling");

  a_strap_code: assert property (
    @(posedge sys_clk_i) default_autoneg_o == default_speed_100_o
      && !default_full_duplex_o)
    else $error("default settings do not follow the strap");

  a_write_gate: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst)
    host_write_accept_o |-> $past(wr_en) && !$past(sleeping))
    else $error("host write accepted before a read");

endmodule : reset_wake_strap_control

// [host_model.sv]
// behavioural host processor on the select and strobe pins of the block
// assumes one clock; pins idle high and change by nba after a rising edge
`timescale 1ns/1ps
module host_model (
  input  wire logic clk_i,
  output logic      host_select_n_o,
  output logic      host_write_strobe_n_o,
  output logic      host_read_strobe_n_o
);
  initial begin
    host_select_n_o       = 1'b1;
    host_write_strobe_n_o = 1'b1;
    host_read_strobe_n_o  = 1'b1;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // a completed read comes first after power-up, reset or wake
  task automatic host_read();
    @(posedge clk_i);
    host_select_n_o      <= 1'b0;
    host_read_strobe_n_o <= 1'b0;
    @(posedge clk_i);
    @(posedge clk_i);
    host_select_n_o      <= 1'b1;
    host_read_strobe_n_o <= 1'b1;
    // the flag lands one edge after the strobes rise
    repeat (2) @(posedge clk_i);
  endtask : host_read

  // the wake access is meant as the byte-order test write; no address
  // reaches this block, so every write cycle looks alike here
  task automatic host_write();
    @(posedge clk_i);
    host_select_n_o       <= 1'b0;
    host_write_strobe_n_o <= 1'b0;
    // one sampled low edge; the accept pulse then stands for the next cycle
    @(posedge clk_i);
    host_select_n_o       <= 1'b1;
    host_write_strobe_n_o <= 1'b1;
  endtask : host_write

  // one cycle of an arbitrary pin pattern, then back to idle
  task automatic pins(input logic sel_n, input logic wr_n);
    @(posedge clk_i);
    host_select_n_o       <= sel_n;
    host_write_strobe_n_o <= wr_n;
    @(posedge clk_i);
    host_select_n_o       <= 1'b1;
    host_write_strobe_n_o <= 1'b1;
    @(posedge clk_i);
  endtask : pins
endmodule : host_model

// [reset_wake_strap_control_tb.sv]
// self-checking bench for the reset, wake-up and strap control block
// assumes the design files and host_model.sv are compiled before it
`include "wake_cfg.svh"
`timescale 1ns/1ps
module reset_wake_strap_control_tb;
  import wake_pkg::*;
  localparam int POR_CYC    = 4;
  localparam int TIME_LIMIT = 5000;

  logic      sys_clk_i;
  logic      nrst_i;
  logic      power_good_i;
  logic      wake_event_i;
  logic      speed_sel_i;
  reg_addr_t reg_addr_i;
  reg_data_t reg_wdata_i;
  logic      reg_wr_i;
  logic      reg_rd_i;
  reg_data_t reg_rdata_o;
  logic      irq_o;
  logic      wake_out;
  logic      wake_oe_n;
  logic      accept;
  logic      power_save_o;
  logic      write_enabled_o;
  logic      speed_100;
  logic      full_duplex;
  logic      autoneg;
  logic      sel_n;
  logic      wr_n;
  logic      rd_n;
  reg_data_t rd;
  logic      pol;
  logic      pp;
  int        fails;
  int        tests_run;
  int        cycles;

  reset_wake_strap_control #(.POR_CYCLES(POR_CYC)) reset_wake_strap_control_inst (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .power_good_i(power_good_i),
    .host_select_n_i(sel_n), .host_write_strobe_n_i(wr_n), .host_read_strobe_n_i(rd_n),
    .wake_event_i(wake_event_i), .speed_sel_i(speed_sel_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .wake_event_out_o(wake_out),
    .wake_event_out_oe_n_o(wake_oe_n), .host_write_accept_o(accept),
    .power_save_o(power_save_o), .write_enabled_o(write_enabled_o),
    .default_speed_100_o(speed_100), .default_full_duplex_o(full_duplex),
    .default_autoneg_o(autoneg));

  host_model host_model_inst (
    .clk_i(sys_clk_i), .host_select_n_o(sel_n),
    .host_write_strobe_n_o(wr_n), .host_read_strobe_n_o(rd_n));

  // ----------------------------------------------------------------
  // clock, watchdog and report
  // ----------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == TIME_LIMIT) begin
      fails++;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // ----------------------------------------------------------------
  // register port master
  // ----------------------------------------------------------------
  task automatic reg_write(input reg_addr_t a, input reg_data_t d);
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input reg_addr_t a, output reg_data_t d);
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : reg_read

  task automatic pulse_event();
    @(posedge sys_clk_i);
    wake_event_i <= 1'b1;
    @(posedge sys_clk_i);
    wake_event_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask : pulse_event

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : settle

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {nrst_i, wake_event_i, reg_wr_i, reg_rd_i} = 4'h0;
    // supply not yet good at power-up, so the power-on counter starts known
    {power_good_i, speed_sel_i} = 2'h1;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 32'h0;
    repeat (6) @(posedge sys_clk_i);
    nrst_i       <= 1'b1;
    power_good_i <= 1'b1;
    settle(POR_CYC + 3);
    check("write_enabled", write_enabled_o, 1'b0);
    check("oe_n", wake_oe_n, 1'b1);
    check("power_save", power_save_o, 1'b0);
    check("speed_100", speed_100, 1'b1);
    check("autoneg", autoneg, 1'b1);
    check("full_duplex", full_duplex, 1'b0);
    reg_read(`OFS_PM_CTRL, rd);
    check("pm_ctrl", rd, 32'h0);
    reg_read(`OFS_PM_STAT, rd);
    check("pm_stat", rd, 32'h8);
    $display("test reset values done");

    reg_write(`OFS_IRQ_MASK, 32'h7);
    host_model_inst.host_write();
    #1 check("accept before read", accept, 1'b0);
    check("irq refused", irq_o, 1'b1);
    reg_read(`OFS_IRQ_STAT, rd);
    check("irq_stat refused", rd, 32'h4);
    check("irq after clear", irq_o, 1'b0);
    $display("test write refused done");

    host_model_inst.host_read();
    #1 check("write_enabled", write_enabled_o, 1'b1);
    host_model_inst.host_write();
    #1 check("accept", accept, 1'b1);
    settle(1);
    check("accept pulse", accept, 1'b0);
    reg_write(8'h10, 32'hFFFFFFFF);
    reg_read(8'h10, rd);
    check("unmapped", rd, 32'h0);
    $display("test read then write done");

    reg_write(`OFS_PM_CTRL, 32'h0);
    pulse_event();
    reg_read(`OFS_PM_STAT, rd);
    check("event disabled", rd, 32'hA);
    for (int i = 0; i < 4; i++) begin
      pol = i[0];
      pp  = i[1];
      reg_write(`OFS_PM_CTRL, {29'h0, pp, pol, 1'b1});
      pulse_event();
      check("pin out", wake_out, pp ? pol : 1'b0);
      check("pin oe_n", wake_oe_n, pp ? 1'b0 : pol);
      reg_read(`OFS_IRQ_STAT, rd);
      check("irq_stat event", rd, 32'h1);
      reg_write(`OFS_PM_STAT, 32'h1);
      settle(1);
      if (pp) check("pin idle", wake_out, !pol);
    end
    $display("test wake pin done");

    @(posedge sys_clk_i);
    nrst_i      <= 1'b0;
    speed_sel_i <= 1'b0;
    settle(2);
    check("write_enabled in reset", write_enabled_o, 1'b0);
    @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    settle(2);
    speed_sel_i <= 1'b1;
    settle(2);
    check("speed_100 held", speed_100, 1'b0);
    check("autoneg off", autoneg, 1'b0);
    reg_read(`OFS_PM_CTRL, rd);
    check("pm_ctrl after reset", rd, 32'h0);
    $display("test hard reset done");

    reg_write(`OFS_PM_CTRL, 32'h9);
    settle(1);
    check("asleep", power_save_o, 1'b1);
    pulse_event();
    settle(1);
    check("event keeps sleep", power_save_o, 1'b1);
    check("pin asserted", wake_oe_n, 1'b0);
    host_model_inst.pins(1'b0, 1'b1);
    host_model_inst.pins(1'b1, 1'b0);
    #1 check("no write cycle", power_save_o, 1'b1);
    host_model_inst.host_read();
    #1 check("read asleep", write_enabled_o, 1'b0);
    host_model_inst.host_write();
    #1 check("woken", power_save_o, 1'b0);
    check("wake not accepted", accept, 1'b0);
    reg_read(`OFS_IRQ_STAT, rd);
    check("irq_stat woke", rd & 32'h3, 32'h3);
    host_model_inst.host_read();
    host_model_inst.host_write();
    #1 check("accept after wake", accept, 1'b1);
    $display("test sleep and wake done");

    @(posedge sys_clk_i);
    power_good_i <= 1'b0;
    @(posedge sys_clk_i);
    power_good_i <= 1'b1;
    settle(1);
    check("por clears flag", write_enabled_o, 1'b0);
    settle(POR_CYC + 3);
    check("por strap", speed_100, 1'b1);
    reg_read(`OFS_PM_STAT, rd);
    check("pm_stat after por", rd, 32'h8);
    $display("test power-on reset done");
    print_verdict();
  end
endmodule : reset_wake_strap_control_tb
